// file: logic/adc_link_pkg.sv
// Shared constants for the serial converter command port and its host
// Notes on behaviour
// R1 - Host writes reference_status_config first, code all-ones
// R2 - Next frame loads output_format_config and converts
// R3 - Control inputs ignored for setup after select
// R4 - Clearing default bit leaves default mode
// R5 - Select high: ignore clock, data; output released
// R6 - Select low starts transfer, drives output
// R7 - Word: upper nibble command, lower nibble data
// R8 - Other codes load output_format_config fields
// R9 - All-ones code loads reference_status_config fields
// R10 - Previous result shifts out during each frame
// R11 - Frame length 8, 12 or 16 clocks
// R12 - Sampling from fourth falling edge to last
// R13 - Last falling edge starts conversion, status low
// R14 - Capture input on first eight rising edges
// R15 - First bit at status rise or select fall
// R16 - Later bits change on falling clock edges
// R17 - Select may stay low; frames by count
// R18 - Data held high loads default configuration
// R19 - Reset clears configuration, status pin high
// R20 - Interrupt mode: low on latch, cleared later
// R21 - Conversion takes 13.5 oscillator clocks plus delay
// R22 - Length field mapping is a parameter
package adc_link_pkg;
  localparam int unsigned SYS_CLK_HZ = 20000000;
  localparam int unsigned CMD_W = 4;
  localparam int unsigned WORD_W = 8;
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [3:0] CMD_CFG2 = 4'hf;
  // Command nibble bit positions inside the input word
  localparam int unsigned CMD_HI = 7;
  localparam int unsigned CMD_LO = 4;
  localparam int unsigned DAT_HI = 3;
  // Field positions inside each configuration nibble
  localparam int unsigned LEN_HI = 3;
  localparam int unsigned LEN_LO = 2;
  localparam int unsigned LSB_FIRST_BIT = 1;
  localparam int unsigned BIPOLAR_BIT = 0;
  localparam int unsigned INT_MODE_BIT = 1;
  localparam int unsigned DEFAULT_BIT = 0;
  // Frame lengths and the edge where sampling opens
  localparam logic [CNT_W-1:0] LEN_8 = 5'h08;
  localparam logic [CNT_W-1:0] LEN_12 = 5'h0c;
  localparam logic [CNT_W-1:0] LEN_16 = 5'h10;
  localparam logic [CNT_W-1:0] SAMPLE_EDGE = 5'h04;
  localparam logic [CNT_W-1:0] CAPTURE_LAST = 5'h08;
  // Length field codes; encoding is not documented here
  localparam logic [1:0] LEN_CODE_8 = 2'h1;
  localparam logic [1:0] LEN_CODE_16 = 2'h3;
  localparam logic [3:0] CFG_RESET = 4'h0;
  // Default configuration: external reference, end-of-conversion, default bit
  localparam logic [3:0] CFG2_DEFAULT = 4'h1;
  // Select setup time and conversion time
  localparam int unsigned CS_SETUP_NS = 100;
  localparam int unsigned CS_SETUP_CYC =
    (CS_SETUP_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned OSC_HALF_NS = 250;
  localparam int unsigned CONV_OSC_HALVES = 27; // 13.5 oscillator clocks
  localparam int unsigned OSC_START_NS = 25;
  localparam int unsigned CONV_NS = OSC_HALF_NS * CONV_OSC_HALVES + OSC_START_NS;
  localparam int unsigned CONV_CYC = (CONV_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CONV_W = 9;
  // Host link clock divider: half period in system cycles
  localparam int unsigned HOST_HALF_CYC = 4;
  localparam int unsigned SYNC_W = 3;
endpackage

// file: logic/adc_link_if.sv
// Serial link between the converter command port and its host
`timescale 1ns/1ps
interface adc_link_if;
  logic cs_n;
  logic io_clk;
  logic data_in;
  logic data_out_o;
  logic data_out_oe;
  logic status_n;
  logic data_out;
  // Wire level: undriven output reads high
  assign data_out = data_out_oe ? data_out_o : 1'b1;
  modport device (input cs_n, input io_clk, input data_in, output data_out_o,
    output data_out_oe, output status_n);
  modport host (output cs_n, output io_clk, output data_in, input data_out,
    input status_n);
endinterface

// file: logic/adc_command_port.sv
// Converter end: frame decode, configuration registers, result shifter
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module adc_command_port (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Serial link
  adc_link_if.device link,
  // Converter core side
  input wire logic [adc_link_pkg::RESULT_W-1:0] conv_value,
  output logic [3:0] output_format_config,
  output logic [3:0] reference_status_config,
  output logic [adc_link_pkg::CMD_W-1:0] channel_sel,
  output logic sampling,
  output logic converting
);
  import adc_link_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_FRAME = 2'b11,
    ST_DONE = 2'b10
  } dev_state_e;

  typedef struct packed {
    logic [SYNC_W-1:0] cs_sync;
    logic [SYNC_W-1:0] clk_sync;
    logic [SYNC_W-1:0] din_sync;
    logic cs_q;
    logic clk_q;
    dev_state_e state;
    logic [CONV_W-1:0] timer;
    logic [CNT_W-1:0] falls;
    logic [CNT_W-1:0] rises;
    logic [WORD_W-1:0] shift_in;
    logic all_ones;
    logic [RESULT_W-1:0] out_reg;
    logic [RESULT_W-1:0] shift_out;
    logic dout;
    logic [3:0] cfg1;
    logic [3:0] cfg2;
    logic [CMD_W-1:0] chan;
    logic sampling;
    logic converting;
    logic status_n;
    logic first_bit_pend;
  } dev_s;

  dev_s s_r;
  dev_s s_nxt;
  logic cs_low;
  logic clk_hi;
  logic din;
  logic clk_rise;
  logic clk_fall;
  logic [CNT_W-1:0] frame_len;
  logic [RESULT_W-1:0] load_word;
  logic [CMD_W-1:0] cmd;
  logic [3:0] cdat;

  // Agreement of the second and third stages filters the select and clock pins
  always_comb begin
    cs_low = (s_r.cs_sync[1] == s_r.cs_sync[2]) ? ~s_r.cs_sync[2] : ~s_r.cs_q;
    clk_hi = (s_r.clk_sync[1] == s_r.clk_sync[2]) ? s_r.clk_sync[2] : s_r.clk_q;
    din = s_r.din_sync[2];
    clk_rise = clk_hi & ~s_r.clk_q;
    clk_fall = ~clk_hi & s_r.clk_q;
  end

  // R22 length mapping
  always_comb begin
    unique case (s_r.cfg1[LEN_HI:LEN_LO])
      LEN_CODE_8: frame_len = LEN_8;
      LEN_CODE_16: frame_len = LEN_16;
      default: frame_len = LEN_12;
    endcase
  end

  // Result is left-justified: MSB-first sends the top bits as they stand; LSB-first
  // reverses the word and lifts the lowest active bit to the head of the shifter
  always_comb begin
    load_word = s_r.out_reg;
    if (s_r.cfg1[LSB_FIRST_BIT]) begin
      load_word = {<<{s_r.out_reg}};
      load_word = load_word << (CNT_W'(RESULT_W) - frame_len);
    end
  end

  always_comb begin
    cmd = s_r.shift_in[CMD_HI:CMD_LO];
    cdat = s_r.shift_in[DAT_HI:0];
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.cs_sync = {s_r.cs_sync[SYNC_W-2:0], link.cs_n};
    s_nxt.clk_sync = {s_r.clk_sync[SYNC_W-2:0], link.io_clk};
    s_nxt.din_sync = {s_r.din_sync[SYNC_W-2:0], link.data_in};
    s_nxt.cs_q = ~cs_low;
    s_nxt.clk_q = clk_hi;
    // R5 select high idles every state but ST_DONE
    if (!cs_low) begin
      if (s_r.state != ST_DONE) begin
        s_nxt.state = ST_IDLE;
      end
    end
    unique case (s_r.state)
      ST_IDLE: begin
        // R6 select fall starts a transfer
        if (cs_low && s_r.cs_q) begin
          s_nxt.state = ST_SETUP;
          s_nxt.timer = '0;
          s_nxt.falls = '0;
          s_nxt.rises = '0;
          s_nxt.all_ones = 1'b1;
          // R15 first bit on select fall
          s_nxt.shift_out = load_word;
          s_nxt.dout = load_word[RESULT_W-1];
          // R20 select fall clears interrupt
          if (s_r.cfg2[INT_MODE_BIT]) begin
            s_nxt.status_n = 1'b1;
          end
        end
      end
      ST_SETUP: begin
        // R3 setup hold-off
        s_nxt.timer = s_r.timer + 1'b1;
        if (s_r.timer >= CONV_W'(CS_SETUP_CYC - 1)) begin
          s_nxt.state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (clk_rise) begin
          s_nxt.rises = s_r.rises + 1'b1;
          // R20 clock rise clears interrupt
          if (s_r.cfg2[INT_MODE_BIT]) begin
            s_nxt.status_n = 1'b1;
          end
          // R14 capture first eight
          if (s_r.rises < CAPTURE_LAST) begin
            s_nxt.shift_in = {s_r.shift_in[WORD_W-2:0], din};
            s_nxt.all_ones = s_r.all_ones & din;
          end
          if (s_r.rises == CAPTURE_LAST - 1'b1) begin
            s_nxt.chan = s_r.shift_in[CMD_HI-1:CMD_LO-1];
          end
        end
        if (clk_fall && s_r.rises != '0) begin
          s_nxt.falls = s_r.falls + 1'b1;
          // R10 R16 next bit on falling edge
          s_nxt.shift_out = {s_r.shift_out[RESULT_W-2:0], 1'b0};
          s_nxt.dout = s_r.shift_out[RESULT_W-2];
          // R12 sampling opens on fourth fall
          if (s_r.falls + 1'b1 == SAMPLE_EDGE) begin
            s_nxt.sampling = 1'b1;
          end
          // R11 R13 last fall ends frame
          if (s_r.falls + 1'b1 == frame_len) begin
            s_nxt.sampling = 1'b0;
            s_nxt.converting = 1'b1;
            s_nxt.timer = '0;
            s_nxt.state = ST_DONE;
            if (!s_r.cfg2[INT_MODE_BIT]) begin
              s_nxt.status_n = 1'b0;
            end
            // R2 R4 R7 R8 R9 R18 configuration load
            if (s_r.all_ones) begin
              s_nxt.cfg2 = CFG2_DEFAULT;
              s_nxt.chan = '0;
            end else if (cmd == CMD_CFG2) begin
              s_nxt.cfg2 = cdat;
            end else begin
              s_nxt.cfg1 = cdat;
            end
          end
        end
      end
      ST_DONE: begin
        // R21 conversion timer
        s_nxt.timer = s_r.timer + 1'b1;
        if (s_r.timer >= CONV_W'(CONV_CYC - 1)) begin
          s_nxt.converting = 1'b0;
          s_nxt.out_reg = conv_value;
          s_nxt.status_n = ~s_r.cfg2[INT_MODE_BIT];
          s_nxt.first_bit_pend = 1'b1;
          // R17 select held low: next frame by count
          s_nxt.state = cs_low ? ST_FRAME : ST_IDLE;
          s_nxt.falls = '0;
          s_nxt.rises = '0;
          s_nxt.all_ones = 1'b1;
        end
      end
    endcase
    // R15 first bit at end of conversion
    if (s_r.first_bit_pend) begin
      s_nxt.first_bit_pend = 1'b0;
      s_nxt.shift_out = load_word;
      s_nxt.dout = load_word[RESULT_W-1];
    end
  end

  // R19 reset state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_r <= '{cs_sync: '1, clk_sync: '0, din_sync: '0, cs_q: 1'b1,
               state: ST_IDLE, cfg1: CFG_RESET, cfg2: CFG_RESET,
               status_n: 1'b1, all_ones: 1'b1, default: '0};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign link.data_out_o = s_r.dout;
  // R5 R6 output driven only while selected
  assign link.data_out_oe = ~s_r.cs_q;
  assign link.status_n = s_r.status_n;
  assign output_format_config = s_r.cfg1;
  assign reference_status_config = s_r.cfg2;
  assign channel_sel = s_r.chan;
  assign sampling = s_r.sampling;
  assign converting = s_r.converting;
endmodule

// file: logic/adc_host_port.sv
// Host end: Avalon-MM slave registers and serial frame master
`timescale 1ns/1ps
module adc_host_port (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial link
  adc_link_if.host link
);
  import adc_link_pkg::*;

  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RESULT = 4'hc;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SETUP = 2'b01,
    H_SHIFT = 2'b11,
    H_END = 2'b10
  } host_state_e;

  typedef struct packed {
    logic [SYNC_W-1:0] dout_sync;
    logic [SYNC_W-1:0] stat_sync;
    host_state_e state;
    logic [WORD_W-1:0] word;
    logic [CNT_W-1:0] length;
    logic hold_cs;
    logic [CNT_W-1:0] edges;
    logic [3:0] div;
    logic [CONV_W-1:0] timer;
    logic cs_n;
    logic io_clk;
    logic din;
    logic [RESULT_W-1:0] rx;
    logic [RESULT_W-1:0] result;
    logic done;
    logic [31:0] rdata;
    logic ack;
  } host_s;

  host_s s_r;
  host_s s_nxt;
  logic dout_bit;

  always_comb begin
    dout_bit = s_r.dout_sync[2];
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.dout_sync = {s_r.dout_sync[SYNC_W-2:0], link.data_out};
    s_nxt.stat_sync = {s_r.stat_sync[SYNC_W-2:0], link.status_n};
    s_nxt.ack = 1'b0;
    // One wait cycle on every access, answer on the next
    if ((avs_read || avs_write) && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      unique case (avs_address)
        REG_STATUS: s_nxt.rdata = {29'h0, s_r.stat_sync[2], s_r.done,
                                   s_r.state != H_IDLE};
        REG_RESULT: s_nxt.rdata = {16'h0, s_r.result};
        REG_CTRL: s_nxt.rdata = {26'h0, s_r.hold_cs, s_r.length};
        default: s_nxt.rdata = 32'h0;
      endcase
      // Clear rides with the capture so a done set in the wait cycle is not lost
      if (avs_read && avs_address == REG_STATUS) begin
        s_nxt.done = 1'b0;
      end
    end
    // Writes land only on the edge that takes the transfer
    if (avs_write && s_r.ack) begin
      if (avs_address == REG_CTRL) begin
        // R11 host supplies exactly programmed count
        s_nxt.length = avs_writedata[CNT_W-1:0];
        s_nxt.hold_cs = avs_writedata[CNT_W];
      end
      if (avs_address == REG_CMD && s_r.state == H_IDLE) begin
        // R1 R7 word launched on command write
        s_nxt.word = avs_writedata[WORD_W-1:0];
        s_nxt.done = 1'b0;
        s_nxt.state = H_SETUP;
        s_nxt.cs_n = 1'b0;
        s_nxt.timer = '0;
        s_nxt.edges = '0;
        s_nxt.div = '0;
      end
    end
    unique case (s_r.state)
      H_IDLE: begin
      end
      H_SETUP: begin
        // R3 wait out setup before clocking
        s_nxt.timer = s_r.timer + 1'b1;
        s_nxt.din = s_r.word[WORD_W-1];
        if (s_r.timer >= CONV_W'(CS_SETUP_CYC + SYNC_W)) begin
          s_nxt.state = H_SHIFT;
        end
      end
      H_SHIFT: begin
        s_nxt.div = s_r.div + 1'b1;
        if (s_r.div == 4'(HOST_HALF_CYC - 1)) begin
          s_nxt.div = '0;
          s_nxt.io_clk = ~s_r.io_clk;
          // Rising edge: device takes din. Falling edge: the returned bit has had the
          // whole period to cross both synchronisers, so it is taken just before the shift
          if (s_r.io_clk) begin
            s_nxt.rx = {s_r.rx[RESULT_W-2:0], dout_bit};
            s_nxt.edges = s_r.edges + 1'b1;
            s_nxt.word = {s_r.word[WORD_W-2:0], 1'b0};
            s_nxt.din = s_r.word[WORD_W-2];
            if (s_r.edges + 1'b1 == s_r.length) begin
              s_nxt.state = H_END;
              s_nxt.timer = '0;
            end
          end
        end
      end
      H_END: begin
        // R17 select stays low if held mode chosen
        s_nxt.timer = s_r.timer + 1'b1;
        if (s_r.timer == CONV_W'(SYNC_W)) begin
          s_nxt.cs_n = s_r.hold_cs ? 1'b0 : 1'b1;
          s_nxt.result = s_r.rx;
          s_nxt.done = 1'b1;
          s_nxt.state = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_r <= '{cs_n: 1'b1, state: H_IDLE, length: LEN_8, stat_sync: '1,
               default: '0};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
  assign avs_readdata = s_r.rdata;
  assign link.cs_n = s_r.cs_n;
  assign link.io_clk = s_r.io_clk;
  assign link.data_in = s_r.din;
endmodule

// file: test/serial_adc_command_port_checker.sv
// Link assertions for the converter command port and its host
`timescale 1ns/1ps
module serial_adc_command_port_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link signals
  input wire logic cs_n,
  input wire logic io_clk,
  input wire logic data_out_o,
  input wire logic data_out_oe,
  input wire logic status_n
);
  import adc_link_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic io_clk_q_r;
  logic [8:0] low_cnt_r;
  logic [8:0] since_fall_r;
  // Status-low time and time since last clock fall; saturate so idles cannot wrap
  always_ff @(posedge sys_clk) begin
    io_clk_q_r <= io_clk;
    if (!reset_n || status_n) begin
      low_cnt_r <= 9'h0;
    end else if (low_cnt_r != 9'h1ff) begin
      low_cnt_r <= low_cnt_r + 9'h1;
    end
    if (!reset_n || (io_clk_q_r && !io_clk)) begin
      since_fall_r <= 9'h0;
    end else if (since_fall_r != 9'h1ff) begin
      since_fall_r <= since_fall_r + 9'h1;
    end
  end
  // Select, release and setup; sync flops allow a few cycles of lag
  oe_idle_a: assert property (cs_n [*5] |-> !data_out_oe)
    else $error("output driven while deselected");
  oe_drive_a: assert property (!cs_n [*6] |-> data_out_oe)
    else $error("output not driven while selected");
  cs_setup_a: assert property ($fell(cs_n) |-> !io_clk [*3])
    else $error("clock started inside select setup");
  clk_idle_a: assert property (cs_n |-> !io_clk)
    else $error("link clock runs while deselected");
  out_stable_a: assert property ($rose(io_clk) |-> ##2 $stable(data_out_o) [*3])
    else $error("output bit changed away from a falling edge");
  status_reset_a: assert property ($rose(reset_n) |-> status_n && !data_out_oe)
    else $error("status or output wrong after reset");
  // Conversion timing seen on the status pin
  conv_time_a: assert property ($rose(status_n) && cs_n |->
    int'(low_cnt_r) >= CONV_CYC - 8 && int'(low_cnt_r) <= CONV_CYC + 8)
    else $error("conversion time out of range");
  status_fall_a: assert property ($fell(status_n) |->
    since_fall_r <= 9'h8 || int'(since_fall_r) >= CONV_CYC - 8)
    else $error("status fell at an unexpected time");
  cover property ($fell(cs_n));
  cover property ($rose(status_n) && !cs_n);
  cover property ($fell(status_n) && since_fall_r > 9'h8);
endmodule

// file: test/serial_adc_command_port_tb.sv
// Self-checking bench: host port driving the converter command port
`timescale 1ns/1ps
module serial_adc_command_port_tb;
  import adc_link_pkg::*;
  logic sys_clk;
  logic reset_n;
  logic clk_en;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [RESULT_W-1:0] conv_value;
  logic [3:0] output_format_config;
  logic [3:0] reference_status_config;
  logic [CMD_W-1:0] channel_sel;
  logic sampling;
  logic converting;
  int bad_count;
  int comparisons;
  int seed;
  int cur_len;
  logic cur_lsb;
  logic keep;
  logic prev_ok;
  logic int_mode;
  int samp_total;
  adc_link_if link_bus ();
  adc_command_port u_adc_command_port (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .link(link_bus), .conv_value(conv_value), .output_format_config(output_format_config),
    .reference_status_config(reference_status_config), .channel_sel(channel_sel),
    .sampling(sampling), .converting(converting));
  adc_host_port u_adc_host_port (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link_bus));
  serial_adc_command_port_checker u_checker (.sys_clk(sys_clk), .reset_n(reset_n),
    .cs_n(link_bus.cs_n), .io_clk(link_bus.io_clk), .data_out_o(link_bus.data_out_o),
    .data_out_oe(link_bus.data_out_oe), .status_n(link_bus.status_n));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog: all frames fit well inside this span
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end
  // Cycles with the sampling window open, for the per-frame window length check
  always @(posedge sys_clk) begin
    if (sampling === 1'b1) samp_total <= samp_total + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus access; an idle edge follows so back-to-back calls never re-drive in one step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    // Wait for waitrequest to drop; only the watchdog ends a stuck wait
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic int len_of(input logic [1:0] c);
    return (c == LEN_CODE_8) ? 8 : (c == LEN_CODE_16) ? 16 : 12;
  endfunction
  // Word the host should assemble from a left-justified result
  function automatic logic [15:0] exp_word(input logic [15:0] v, input int n, input logic lsb);
    logic [15:0] r;
    r = 16'h0;
    for (int j = 0; j < n; j++) r[j] = lsb ? v[15-j] : v[16-n+j];
    return r;
  endfunction
  // One frame: launch, wait, then check result, status and configuration
  task automatic frame(input logic [7:0] w);
    logic [31:0] q;
    logic [15:0] old;
    int n;
    int base;
    old = conv_value;
    base = samp_total;
    conv_value <= 16'($random(seed));
    bus(1'b1, 4'h4, {26'h0, keep, 5'(cur_len)}, q);
    bus(1'b1, 4'h0, {24'h0, w}, q);
    q = 32'h0;
    for (n = 0; n < 300 && q[1] !== 1'b1; n++) bus(1'b0, 4'h8, 32'h0, q);
    check({31'h0, q[1]}, 32'h1);
    bus(1'b0, 4'hc, 32'h0, q);
    if (prev_ok) check({16'h0, q[15:0] & 16'((32'h1 << cur_len) - 1)},
      {16'h0, exp_word(old, cur_len, cur_lsb)});
    check({30'h0, sampling, converting}, 32'h1);
    check(samp_total - base, (cur_len - int'(SAMPLE_EDGE)) * 2 * int'(HOST_HALF_CYC));
    repeat (CONV_CYC + 40) @(posedge sys_clk);
    check({30'h0, sampling, converting}, 32'h0);
    if (w[7:4] == CMD_CFG2) int_mode = w[INT_MODE_BIT] && (w != 8'hff);
    bus(1'b0, 4'h8, 32'h0, q);
    check({31'h0, q[2]}, {31'h0, !int_mode});
    if (w[7:4] == CMD_CFG2) begin
      check({28'h0, reference_status_config},
        {28'h0, (w == 8'hff) ? CFG2_DEFAULT : w[3:0]});
      prev_ok = 1'b0;
    end else begin
      check({24'h0, channel_sel, output_format_config}, {24'h0, w});
      cur_len = len_of(w[LEN_HI:LEN_LO]);
      cur_lsb = w[LSB_FIRST_BIT];
      prev_ok = !w[BIPOLAR_BIT];
    end
  endtask
  // Main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    seed = 32'hd8e2;
    bad_count = 0;
    comparisons = 0;
    cur_len = 12;
    cur_lsb = 1'b0;
    keep = 1'b0;
    prev_ok = 1'b0;
    int_mode = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    conv_value = 16'h0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    check({24'h0, reference_status_config, output_format_config}, 32'h0);
    bus(1'b0, 4'h8, 32'h0, q);
    check({31'h0, q[2]}, 32'h1);
    bus(1'b0, 4'h6, 32'h0, q);
    check(q, 32'h0);
    bus(1'b1, 4'h4, 32'h2c, q);
    bus(1'b0, 4'h4, 32'h0, q);
    check(q, 32'h2c);
    frame(8'hff);
    frame(8'hf0);
    frame(8'h31);
    frame(8'h04);
    frame(8'h2e);
    // Random traffic; the last few hold select low between frames
    for (int i = 0; i < 15; i++) begin
      r = $random(seed);
      keep = (i >= 12);
      frame({(r[3:0] == 4'hf) ? 4'he : r[3:0], r[7:5], 1'b0});
    end
    keep = 1'b0;
    frame(8'hf2);
    frame(8'h08);
    frame(8'hf0);
    frame(8'h00);
    close_out();
  end
endmodule
